// ===== logic/lan_status_event_flags.sv
`timescale 1ns/10ps
module lan_status_event_flags (
    input  wire logic                    sys_clk,
    input  wire logic                    resetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [7:0]              paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire lan_status_pkg::events_s events,
    input  wire logic                    rx_poll_demand,
    input  wire logic                    tx_resume,
    output logic                         rx_suspended_out,
    output logic                         tx_suspended_out,
    output logic                         tx_desc_underflow_set,
    output logic                         irq
);
    import lan_status_pkg::*;

    logic   [1:0] rst_sync_q;
    logic         rst_n;
    state_s       s_q;
    state_s       s_d;
    logic         wr;
    logic         rd;
    logic         link_qual;
    logic [12:0]  set_v;
    logic [12:0]  clr_v;
    logic         abnormal_sum;
    logic         normal_sum;
    logic [31:0]  rdata_d;
    logic         addr_ok;
    logic [31:0]  prdata_q;
    logic         underflow_mark_q;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign addr_ok = (paddr == status_offset) || (paddr == mask_offset) ||
                     (paddr == control_offset) || (paddr == rx_state_offset);
    assign link_qual = !s_q.control[port_select_bit] && s_q.control[squelch_enable_bit] &&
                       !s_q.control[medium_select_bit];

    always_comb begin
        s_d   = s_q;
        set_v = 13'h0000;
        clr_v = 13'h0000;
        set_v[link_fail_bit]     = events.link_fail_enter && link_qual;
        set_v[timer_expired_bit] = events.timer_expired;
        set_v[early_tx_bit]      = events.early_tx;
        set_v[rx_watchdog_bit]   = events.rx_watchdog;
        set_v[rx_complete_bit]   = events.rx_frame_done;
        set_v[underflow_bit]     = events.tx_underflow;
        set_v[tx_complete_bit]   = events.tx_complete;
        set_v[link_pass_bit]     = (!s_q.control[autoneg_enable_bit] && events.link_pass_test) ||
                                   (s_q.control[autoneg_enable_bit] && events.autoneg_done);
        if (wr && paddr == control_offset && s_q.control[link_test_en_bit] &&
            !pwdata[link_test_en_bit]) begin
            set_v[link_pass_bit] = 1'b1;
        end
        // receive process
        case (s_q.rx_state)
            rx_stopped: begin
                if (events.rx_start) begin
                    s_d.rx_state = rx_running;
                end
            end
            rx_running: begin
                if (events.rx_stop) begin
                    s_d.rx_state = rx_stopped;
                    set_v[rx_stopped_bit] = 1'b1;
                end else if (events.rx_desc_host_owned) begin
                    s_d.rx_state = rx_suspended;
                    set_v[rx_unavail_bit] = s_q.prev_desc_owned;
                    s_d.prev_desc_owned = 1'b0;
                end else if (events.rx_frame_done) begin
                    s_d.prev_desc_owned = 1'b1;
                end
            end
            rx_suspended: begin
                if (events.rx_stop) begin
                    s_d.rx_state = rx_stopped;
                    set_v[rx_stopped_bit] = 1'b1;
                end else if (rx_poll_demand || events.rx_frame_seen) begin
                    s_d.rx_state = rx_running;
                    s_d.prev_desc_owned = 1'b1;
                end
            end
            default: begin
                s_d.rx_state = rx_stopped;
            end
        endcase
        // transmit suspend on underflow
        if (events.tx_underflow) begin
            s_d.tx_suspend = 1'b1;
        end else if (tx_resume) begin
            s_d.tx_suspend = 1'b0;
        end
        // write-one-to-clear and automatic clears
        if (wr && paddr == status_offset) begin
            clr_v = pwdata[12:0] & flag_field;
        end
        if (set_v[link_pass_bit]) begin
            clr_v[link_fail_bit] = 1'b1;
        end
        if (set_v[link_fail_bit]) begin
            clr_v[link_pass_bit] = 1'b1;
        end
        if (set_v[tx_complete_bit]) begin
            clr_v[early_tx_bit] = 1'b1;
        end
        s_d.flags = ((s_q.flags & ~clr_v) | set_v) & flag_field;
        // an early transmit cleared by completion keeps its own set over other clears
        if (set_v[early_tx_bit]) begin
            s_d.flags[early_tx_bit] = 1'b1;
        end
        if (wr && paddr == mask_offset) begin
            s_d.mask = pwdata[12:0] & flag_field;
        end
        if (wr && paddr == control_offset) begin
            s_d.control = pwdata[4:0];
        end
    end

    // early transmit summary latch survives the automatic clear
    logic eti_hold_q;
    logic eti_hold_d;
    always_comb begin
        eti_hold_d = eti_hold_q;
        if (s_q.flags[early_tx_bit] && s_q.mask[early_tx_bit] && set_v[tx_complete_bit]) begin
            eti_hold_d = 1'b1;
        end
        if (wr && paddr == status_offset && pwdata[early_tx_bit]) begin
            eti_hold_d = 1'b0;
        end
    end

    assign abnormal_sum = |(s_q.flags & s_q.mask & abnormal_set) || eti_hold_q;
    assign normal_sum   = |(s_q.flags & s_q.mask & normal_set);

    always_comb begin
        rdata_d = 32'h0000_0000;
        case (paddr)
            status_offset: begin
                rdata_d[12:0]            = s_q.flags;
                rdata_d[abnormal_sum_bit] = abnormal_sum;
                rdata_d[normal_sum_bit]   = normal_sum;
            end
            mask_offset: begin
                rdata_d[12:0] = s_q.mask;
            end
            control_offset: begin
                rdata_d[4:0] = s_q.control;
            end
            rx_state_offset: begin
                rdata_d[1:0] = s_q.rx_state;
                rdata_d[2]   = s_q.tx_suspend;
            end
            default: begin
                rdata_d = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q              <= '{flags: 13'h0000, mask: 13'h0000, control: control_reset,
                                  rx_state: rx_stopped, prev_desc_owned: 1'b1, tx_suspend: 1'b0};
            eti_hold_q       <= 1'b0;
            prdata_q         <= 32'h0000_0000;
            underflow_mark_q <= 1'b0;
        end else begin
            s_q              <= s_d;
            eti_hold_q       <= eti_hold_d;
            prdata_q         <= psel && !penable && !pwrite ? rdata_d : prdata_q;
            underflow_mark_q <= events.tx_underflow;
        end
    end

    assign prdata                = prdata_q;
    assign pready                = 1'b1;
    assign pslverr               = psel && penable && !addr_ok;
    assign rx_suspended_out      = s_q.rx_state == rx_suspended;
    assign tx_suspended_out      = s_q.tx_suspend;
    assign tx_desc_underflow_set = underflow_mark_q;
    assign irq                   = abnormal_sum || normal_sum;
endmodule

// ===== logic/lan_status_pkg.sv
package lan_status_pkg;
    // register byte offsets
    localparam logic [7:0] status_offset      = 8'h00;
    localparam logic [7:0] mask_offset        = 8'h04;
    localparam logic [7:0] control_offset     = 8'h08;
    localparam logic [7:0] rx_state_offset    = 8'h0c;
    // flag bit positions inside the status word
    localparam int tx_complete_bit     = 0;
    localparam int link_pass_bit       = 4;
    localparam int underflow_bit       = 5;
    localparam int rx_complete_bit     = 6;
    localparam int rx_unavail_bit      = 7;
    localparam int rx_stopped_bit      = 8;
    localparam int rx_watchdog_bit     = 9;
    localparam int early_tx_bit        = 10;
    localparam int timer_expired_bit   = 11;
    localparam int link_fail_bit       = 12;
    localparam int abnormal_sum_bit    = 15;
    localparam int normal_sum_bit      = 16;
    // control register bit positions
    localparam int port_select_bit     = 0;
    localparam int squelch_enable_bit  = 1;
    localparam int medium_select_bit   = 2;
    localparam int autoneg_enable_bit  = 3;
    localparam int link_test_en_bit    = 4;
    localparam logic [31:0] status_reset  = 32'h0000_0000;
    localparam logic [31:0] mask_reset    = 32'h0000_0000;
    localparam logic [4:0]  control_reset = 5'h12;
    localparam logic [12:0] flag_field    = 13'h1ff1;
    localparam logic [12:0] abnormal_set  = 13'h17b0;
    localparam logic [12:0] normal_set    = 13'h0841;

    typedef enum logic [1:0] {
        rx_stopped,
        rx_running,
        rx_suspended
    } rx_state_e;

    typedef struct packed {
        logic tx_complete;
        logic link_pass_test;
        logic autoneg_done;
        logic link_fail_enter;
        logic timer_expired;
        logic early_tx;
        logic rx_watchdog;
        logic rx_start;
        logic rx_stop;
        logic rx_desc_host_owned;
        logic rx_frame_done;
        logic rx_frame_seen;
        logic tx_underflow;
    } events_s;

    typedef struct packed {
        logic [12:0] flags;
        logic [12:0] mask;
        logic [4:0]  control;
        rx_state_e   rx_state;
        logic        prev_desc_owned;
        logic        tx_suspend;
    } state_s;
endpackage

// ===== dv/lan_flags_sva.sv
`timescale 1ns/10ps
module lan_flags_sva
    import lan_status_pkg::*;
(
    input wire logic                    sys_clk,
    input wire logic                    resetn,
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pwrite,
    input wire lan_status_pkg::events_s events,
    input wire logic                    rx_poll_demand,
    input wire logic                    tx_resume,
    input wire logic                    rx_suspended_out,
    input wire logic                    tx_suspended_out,
    input wire logic                    tx_desc_underflow_set,
    input wire logic                    irq
);
    import lan_status_pkg::*;
    wire quiet = !(psel && penable && pwrite) && !(events.link_pass_test || events.autoneg_done || events.link_fail_enter);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    a_unf_desc_pulse: assert property (events.tx_underflow |=> tx_desc_underflow_set ##1 !tx_desc_underflow_set)
        else $error("descriptor underflow pulse wrong");
    a_unf_tx_suspend: assert property (events.tx_underflow |=> tx_suspended_out)
        else $error("transmit not suspended");
    a_tx_susp_holds: assert property (tx_suspended_out && !tx_resume |=> $stable(tx_suspended_out))
        else $error("transmit suspend dropped");
    a_frame_resumes_rx: assert property (rx_suspended_out && events.rx_frame_seen && !events.rx_stop |=> !rx_suspended_out)
        else $error("frame did not resume receive");
    a_poll_resumes_rx: assert property (rx_suspended_out && rx_poll_demand && !events.rx_stop |=> !rx_suspended_out)
        else $error("poll did not resume receive");
    a_stop_ends_susp: assert property (events.rx_stop |=> !rx_suspended_out)
        else $error("receive still suspended after stop");
    a_done_keeps_run: assert property (!rx_suspended_out && events.rx_frame_done && !events.rx_desc_host_owned
        |=> !rx_suspended_out)
        else $error("frame completion suspended receive");
    a_irq_sticky: assert property (irq && quiet |=> irq)
        else $error("interrupt dropped without clear");
    c_underflow: cover property (events.tx_underflow);
    c_poll: cover property (rx_suspended_out && rx_poll_demand);
    c_frame: cover property (rx_suspended_out && events.rx_frame_seen);
endmodule
bind lan_status_event_flags lan_flags_sva u_sva (.sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .events(events), .rx_poll_demand(rx_poll_demand), .tx_resume(tx_resume),
    .rx_suspended_out(rx_suspended_out), .tx_suspended_out(tx_suspended_out),
    .tx_desc_underflow_set(tx_desc_underflow_set), .irq(irq));

// ===== dv/lan_far_side.sv
`timescale 1ns/10ps
module lan_far_side
    import lan_status_pkg::*;
(
    input  wire logic              sys_clk,
    output lan_status_pkg::events_s events,
    output logic                   rx_poll_demand,
    output logic                   tx_resume
);
    import lan_status_pkg::*;
    logic host_owns_q = 1'b1;
    initial events = '0;
    initial rx_poll_demand = 1'b0;
    initial tx_resume = 1'b0;
    task automatic fire(input logic [12:0] v);
        @(posedge sys_clk);
        events <= events_s'(v);
        @(posedge sys_clk);
        events <= '0;
    endtask
    // descriptor fetch: host-owned or a finished frame
    task automatic fetch();
        fire(host_owns_q ? 13'h0008 : 13'h0004);
    endtask
    // ownership back to device, then poll demand
    task automatic hand_back();
        host_owns_q = 1'b0;
        @(posedge sys_clk);
        rx_poll_demand <= 1'b1;
        @(posedge sys_clk);
        rx_poll_demand <= 1'b0;
    endtask
    task automatic resume_tx();
        @(posedge sys_clk);
        tx_resume <= 1'b1;
        @(posedge sys_clk);
        tx_resume <= 1'b0;
    endtask
endmodule

// ===== dv/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import lan_status_pkg::*;
    logic        sys_clk, resetn, psel, penable, pwrite, pready, pslverr, poll, resume, rxs, txs, irq, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    events_s     events;
    int          fails, checks_done;
    lan_status_event_flags u_dut (.sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .events(events), .rx_poll_demand(poll), .tx_resume(resume), .rx_suspended_out(rxs),
        .tx_suspended_out(txs), .tx_desc_underflow_set(), .irq(irq));
    lan_far_side u_far (.sys_clk(sys_clk), .events(events), .rx_poll_demand(poll), .tx_resume(resume));
    always #25 sys_clk = ~sys_clk;
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(what, rd, exp);
    endtask
    task automatic t_regs();
        rdchk("status", 8'h00, 32'h0000_0000);
        rdchk("mask", 8'h04, 32'h0000_0000);
        rdchk("control", 8'h08, 32'h0000_0012);
        rdchk("unmapped", 8'h10, 32'h0000_0000);
        check("slverr", 32'(err), 32'h0000_0001);
    endtask
    task automatic t_link();
        apb(1'b1, 8'h04, 32'h0000_1ff1);
        apb(1'b1, 8'h08, 32'h0000_0002);
        rdchk("test off", 8'h00, 32'h0000_8010);
        u_far.fire(13'h0200);
        rdchk("fail", 8'h00, 32'h0000_9000);
        u_far.fire(13'h0800);
        rdchk("pass", 8'h00, 32'h0000_8010);
        apb(1'b1, 8'h00, 32'h0000_0010);
        apb(1'b1, 8'h08, 32'h0000_0003);
        u_far.fire(13'h0200);
        rdchk("fail gated", 8'h00, 32'h0000_0000);
        apb(1'b1, 8'h08, 32'h0000_000a);
        u_far.fire(13'h0800);
        rdchk("test ignored", 8'h00, 32'h0000_0000);
        u_far.fire(13'h0400);
        rdchk("autoneg", 8'h00, 32'h0000_8010);
        apb(1'b1, 8'h00, 32'h0000_0010);
        @(negedge sys_clk);
        check("irq idle", 32'(irq), 32'h0000_0000);
    endtask
    task automatic t_tx();
        u_far.fire(13'h0080);
        rdchk("early", 8'h00, 32'h0000_8400);
        u_far.fire(13'h1000);
        rdchk("tx done", 8'h00, 32'h0001_8001);
        apb(1'b1, 8'h00, 32'h0000_0400);
        rdchk("early clr", 8'h00, 32'h0001_0001);
        apb(1'b1, 8'h00, 32'h0000_0001);
        u_far.fire(13'h0001);
        rdchk("underflow", 8'h00, 32'h0000_8020);
        check("tx susp", 32'(txs), 32'h0000_0001);
        u_far.resume_tx();
        apb(1'b1, 8'h00, 32'h0000_0020);
        check("tx resumed", 32'(txs), 32'h0000_0000);
        u_far.fire(13'h0100);
        u_far.fire(13'h0040);
        rdchk("timer wdog", 8'h00, 32'h0001_8a00);
        apb(1'b1, 8'h04, 32'h0000_0000);
        rdchk("masked", 8'h00, 32'h0000_0a00);
        @(negedge sys_clk);
        check("irq masked", 32'(irq), 32'h0000_0000);
        apb(1'b1, 8'h04, 32'h0000_1ff1);
        apb(1'b1, 8'h00, 32'h0000_0a00);
    endtask
    task automatic t_rx();
        u_far.fire(13'h0020);
        u_far.fetch();
        rdchk("unavail", 8'h00, 32'h0000_8080);
        check("rx susp", 32'(rxs), 32'h0000_0001);
        apb(1'b1, 8'h00, 32'h0000_0080);
        u_far.fetch();
        rdchk("no repeat", 8'h00, 32'h0000_0000);
        u_far.fire(13'h0002);
        rdchk("frame resume", 8'h0c, 32'h0000_0001);
        u_far.host_owns_q = 1'b0;
        u_far.fetch();
        rdchk("rx done", 8'h00, 32'h0001_0040);
        rdchk("still run", 8'h0c, 32'h0000_0001);
        apb(1'b1, 8'h00, 32'h0000_0040);
        u_far.host_owns_q = 1'b1;
        u_far.fetch();
        rdchk("unavail again", 8'h00, 32'h0000_8080);
        u_far.hand_back();
        rdchk("poll resume", 8'h0c, 32'h0000_0001);
        u_far.fire(13'h0010);
        rdchk("stopped", 8'h00, 32'h0000_8180);
        rdchk("stop state", 8'h0c, 32'h0000_0000);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        resetn  = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
        repeat (10) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        t_regs();
        t_link();
        t_tx();
        t_rx();
        conclude();
    end
    initial begin
        #200000;
        fails++;
        conclude();
    end
endmodule
